// ==== rtl/uio_params.svh ====
// constants of the channel i/o port block: addresses, masks, reset values
// assumes an 8-bit parallel register bus with a 7-bit address
// Operation
// - change field reads zero when detection is off or pin drives out
// - port B upper change status: pins 6 and 4 flags and levels
// - port A level register returns all eight pin levels
// - port B level register returns pins 6, 4, 3, 2 and 0 only
// - enable bit set turns a pin's detector on; B bits 7,5,1 reserved
// - enabled detector keeps flagging changes while the pin is an output
// - two-bit field per pin, four fields per config register
// - port B pin 0 carries request-to-send or end of transmission per mode
// - code 00 only disables the driver; input and detector stay active
// - reset clears all config registers, all pins come up as inputs
// - an input pin is general input and alternate input at once
// - port A pin 3 and pin 1 field encodings
// - port A pin 2 and pin 0 field encodings
// - port A pin 7 and pin 6 field encodings
// - port A pin 4 and pin 5 field encodings
// - port B pin 3 and pin 0 encodings; bits 3:2 reserved
// - port B pin 2 encodings incl. counter 1 open-drain output
// - port B pin 6 and pin 4 encodings incl. interrupt open-drain outputs
// - port B upper config reads zero in bits 7:6 and 3:2
// - latch code drives the pin with the inverse of the latch bit
`ifndef UIO_PARAMS_SVH
`define UIO_PARAMS_SVH

// write addresses
`define UIO_WA_CFG0 7'h13
`define UIO_WA_CFG1 7'h14
`define UIO_WA_CFG2 7'h1b
`define UIO_WA_CFG3 7'h1c
`define UIO_A_ENA 7'h32
`define UIO_A_ENB 7'h3a
// read addresses
`define UIO_RA_CHG_AU 7'h13
`define UIO_RA_CHG_AL 7'h14
`define UIO_RA_LVL_A 7'h15
`define UIO_RA_CHG_BL 7'h1a
`define UIO_RA_CHG_BU 7'h1b
`define UIO_RA_CFG3 7'h1c
`define UIO_RA_LVL_B 7'h1d
`define UIO_RA_CFG0 7'h40
`define UIO_RA_CFG1 7'h41
`define UIO_RA_CFG2 7'h42
`define UIO_RA_CFG3B 7'h43

`define UIO_CFG_RST 8'h00
`define UIO_EN_RST 8'h00
// pins that exist on each port
`define UIO_PA_PINS 8'hff
`define UIO_PB_PINS 8'h5d
// pins with an alternate source on code 10 / code 11, and open-drain ones
`define UIO_PA_ALT10 8'h9c
`define UIO_PB_ALT10 8'h54
`define UIO_PB_OD10 8'h50
`define UIO_PB_ALT11 8'h0c
// readable bits of the port B config registers
`define UIO_CFG2_MASK 8'hf3
`define UIO_CFG3_MASK 8'h33
// detector priming: cycles before stage three holds a real sample
`define UIO_PRIME_DONE 2'h3
`define UIO_PRIME_W 2

`endif

// ==== rtl/uio_pkg.sv ====
// types of the channel i/o port block
// assumes uio_params.svh provides the numeric constants
`default_nettype none
package uio_pkg;
  typedef enum logic [1:0] {
    UIO_IN = 2'h0,
    UIO_LATCH = 2'h1,
    UIO_ALT_A = 2'h2,
    UIO_ALT_B = 2'h3
  } uio_code_e;
endpackage
`default_nettype wire

// ==== rtl/uio_chg_if.sv ====
// carrier between the port top and its change detector
// assumes one clock domain shared by both ends
`default_nettype none
interface uio_chg_if #(parameter int W = 8);
  logic [W-1:0] en;
  logic [W-1:0] clr;
  logic [W-1:0] lvl;
  logic [W-1:0] flag;
  modport det (input en, input clr, output lvl, output flag);
  modport ctl (output en, output clr, input lvl, input flag);
endinterface
`default_nettype wire

// ==== rtl/uio_chg_det.sv ====
// per-pin synchroniser and sticky change-of-state detector
// assumes pins may be asynchronous; clear comes from a register read
`include "uio_params.svh"
`default_nettype none
module uio_chg_det #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  uio_chg_if.det chg
);
  logic [`UIO_PRIME_W-1:0] prime_r;
  logic primed;

  // no edge is trusted until stage three holds a real sample
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prime_r <= '0;
    end else if (prime_r != `UIO_PRIME_DONE) begin
      prime_r <= prime_r + 1'b1;
    end
  end
  assign primed = (prime_r == `UIO_PRIME_DONE);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic set;
    logic flag_r;

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end else begin
        s1_r <= pin_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end

    // detector runs whatever the pin direction
    assign set = chg.en[i] && primed && (s2_r ^ s3_r);

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        flag_r <= 1'b0;
      end else if (set) begin
        flag_r <= 1'b1;
      end else if (chg.clr[i]) begin
        flag_r <= 1'b0;
      end
    end

    assign chg.flag[i] = flag_r;
    assign chg.lvl[i] = s2_r;
  end
endmodule
`default_nettype wire

// ==== rtl/uio_port_top.sv ====
// channel multipurpose i/o ports A and B with change detectors
// assumes a single-cycle read/write strobe bus; pins resolved outside
`include "uio_params.svh"
`default_nettype none
module uio_port_top #(
  parameter int NPIN = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  // register bus
  input wire logic [6:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // pins
  input wire logic [NPIN-1:0] pa_in,
  output logic [NPIN-1:0] pa_out,
  output logic [NPIN-1:0] pa_oe,
  input wire logic [NPIN-1:0] pb_in,
  output logic [NPIN-1:0] pb_out,
  output logic [NPIN-1:0] pb_oe,
  // output latch contents and mode controls from the channel
  input wire logic [NPIN-1:0] output_latch_a,
  input wire logic [NPIN-1:0] output_latch_b,
  input wire logic rts_mode_en,
  input wire logic eot_mode_en,
  input wire logic request_to_send_n,
  input wire logic end_of_tx_n,
  // alternate sources driven onto pins
  input wire logic transmit_clock_16x,
  input wire logic transmit_clock_1x,
  input wire logic chb_transmit_clock_1x,
  input wire logic receive_clock_16x,
  input wire logic receive_clock_1x,
  input wire logic ct0_out,
  input wire logic ct1_out,
  input wire logic transmit_interrupt_out_n,
  input wire logic receive_interrupt_out_n,
  // alternate inputs taken from pins
  output logic clear_to_send_n,
  output logic transmit_clock_in,
  output logic receive_clock_in,
  output logic ct0_clock,
  output logic ct1_clock,
  output logic baud_generator_clock0,
  output logic baud_generator_clock1,
  output logic set_ready_n,
  output logic ring_indicator_n,
  output logic carrier_detect_n
);
  logic [7:0] pin_config_0_r;
  logic [7:0] pin_config_1_r;
  logic [7:0] pin_config_2_r;
  logic [7:0] pin_config_3_r;
  logic [7:0] en_a_r;
  logic [7:0] en_b_r;
  logic [15:0] cfg_a;
  logic [15:0] cfg_b;
  logic [NPIN-1:0] in_mode_a;
  logic [NPIN-1:0] in_mode_b;
  logic [NPIN-1:0] rep_a;
  logic [NPIN-1:0] rep_b;
  logic [NPIN-1:0] latch_b_eff;
  logic [NPIN-1:0] alt10_a;
  logic [NPIN-1:0] alt10_b;
  logic [NPIN-1:0] alt11_b;
  logic [NPIN-1:0] pa_out_nxt;
  logic [NPIN-1:0] pa_oe_nxt;
  logic [NPIN-1:0] pb_out_nxt;
  logic [NPIN-1:0] pb_oe_nxt;
  logic [NPIN-1:0] clr_a;
  logic [NPIN-1:0] clr_b;
  logic [7:0] rdata_nxt;
  logic wr_cfg0;
  logic wr_cfg1;
  logic wr_cfg2;
  logic wr_cfg3;

  uio_chg_if #(.W(NPIN)) chg_a ();
  uio_chg_if #(.W(NPIN)) chg_b ();

  uio_chg_det #(.W(NPIN)) u_det_a (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(pa_in),
    .chg(chg_a.det)
  );

  uio_chg_det #(.W(NPIN)) u_det_b (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(pb_in),
    .chg(chg_b.det)
  );

  // ---- configuration registers
  assign wr_cfg0 = bus_wr && (bus_addr == `UIO_WA_CFG0);
  assign wr_cfg1 = bus_wr && (bus_addr == `UIO_WA_CFG1);
  assign wr_cfg2 = bus_wr && (bus_addr == `UIO_WA_CFG2);
  assign wr_cfg3 = bus_wr && (bus_addr == `UIO_WA_CFG3);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_config_0_r <= `UIO_CFG_RST;
      pin_config_1_r <= `UIO_CFG_RST;
    end else begin
      if (wr_cfg0) begin
        pin_config_0_r <= bus_wdata;
      end
      if (wr_cfg1) begin
        pin_config_1_r <= bus_wdata;
      end
    end
  end

  // reserved port B fields are never stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_config_2_r <= `UIO_CFG_RST;
      pin_config_3_r <= `UIO_CFG_RST;
    end else begin
      if (wr_cfg2) begin
        pin_config_2_r <= bus_wdata & `UIO_CFG2_MASK;
      end
      if (wr_cfg3) begin
        pin_config_3_r <= bus_wdata & `UIO_CFG3_MASK;
      end
    end
  end

  // ---- change detect enables
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_a_r <= `UIO_EN_RST;
      en_b_r <= `UIO_EN_RST;
    end else if (bus_wr) begin
      if (bus_addr == `UIO_A_ENA) begin
        en_a_r <= bus_wdata;
      end
      if (bus_addr == `UIO_A_ENB) begin
        en_b_r <= bus_wdata & `UIO_PB_PINS;
      end
    end
  end

  assign chg_a.en = en_a_r;
  assign chg_b.en = en_b_r;

  // ---- per-pin field decode
  assign cfg_a = {pin_config_1_r, pin_config_0_r};
  assign cfg_b = {pin_config_3_r, pin_config_2_r};

  // pin 0 of port B follows the mode-driven line when one is selected
  always_comb begin
    latch_b_eff = output_latch_b;
    if (rts_mode_en) begin
      latch_b_eff[0] = ~request_to_send_n;
    end else if (eot_mode_en) begin
      latch_b_eff[0] = ~end_of_tx_n;
    end
  end

  // code 10 sources per pin
  assign alt10_a = {chb_transmit_clock_1x, 2'h0, receive_clock_16x,
                    transmit_clock_16x, transmit_clock_1x, 2'h0};
  assign alt10_b = {1'b0, transmit_interrupt_out_n, 1'b0,
                    receive_interrupt_out_n, 1'b0, receive_clock_1x, 2'h0};
  // code 11 sources per pin
  assign alt11_b = {4'h0, ct0_out, ct1_out, 2'h0};

  // {oe, out} for one pin; open-drain pulls low only
  function automatic logic [1:0] pin_drive(
    input logic [1:0] code,
    input logic exists,
    input logic latch,
    input logic v10,
    input logic od10,
    input logic s10,
    input logic v11,
    input logic s11
  );
    logic [1:0] r;
    r = 2'h0;
    unique case (uio_pkg::uio_code_e'(code))
      uio_pkg::UIO_IN: begin
        r = 2'h0;
      end
      uio_pkg::UIO_LATCH: begin
        if (exists) begin
          r = {1'b1, ~latch};
        end
      end
      uio_pkg::UIO_ALT_A: begin
        if (v10 && od10) begin
          r = {~s10, 1'b0};
        end else if (v10) begin
          r = {1'b1, s10};
        end
      end
      uio_pkg::UIO_ALT_B: begin
        if (v11) begin
          r = {~s11, 1'b0};
        end
      end
    endcase
    return r;
  endfunction

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic [1:0] da;
    logic [1:0] db;
    localparam logic [7:0] PA_PINS = `UIO_PA_PINS;
    localparam logic [7:0] PB_PINS = `UIO_PB_PINS;
    localparam logic [7:0] PA_ALT10 = `UIO_PA_ALT10;
    localparam logic [7:0] PB_ALT10 = `UIO_PB_ALT10;
    localparam logic [7:0] PB_OD10 = `UIO_PB_OD10;
    localparam logic [7:0] PB_ALT11 = `UIO_PB_ALT11;

    // port A: clocks on pins 2,3,4,7 under code 10
    assign da = pin_drive(cfg_a[2*i+1:2*i], PA_PINS[i], output_latch_a[i],
                          PA_ALT10[i], 1'b0, alt10_a[i], 1'b0,
                          1'b0);
    // port B: interrupts and counter outputs are open-drain
    assign db = pin_drive(cfg_b[2*i+1:2*i], PB_PINS[i], latch_b_eff[i],
                          PB_ALT10[i], PB_OD10[i], alt10_b[i],
                          PB_ALT11[i], alt11_b[i]);
    assign pa_oe_nxt[i] = da[1];
    assign pa_out_nxt[i] = da[0];
    assign pb_oe_nxt[i] = db[1];
    assign pb_out_nxt[i] = db[0];
    assign in_mode_a[i] = (cfg_a[2*i+1:2*i] == uio_pkg::UIO_IN);
    assign in_mode_b[i] = (cfg_b[2*i+1:2*i] == uio_pkg::UIO_IN);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pa_out <= '0;
      pa_oe <= '0;
      pb_out <= '0;
      pb_oe <= '0;
    end else begin
      pa_out <= pa_out_nxt;
      pa_oe <= pa_oe_nxt;
      pb_out <= pb_out_nxt;
      pb_oe <= pb_oe_nxt;
    end
  end

  // ---- alternate inputs, live whatever the pin code
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clear_to_send_n <= 1'b0;
      transmit_clock_in <= 1'b0;
      receive_clock_in <= 1'b0;
      ct0_clock <= 1'b0;
      ct1_clock <= 1'b0;
      baud_generator_clock0 <= 1'b0;
      baud_generator_clock1 <= 1'b0;
    end else begin
      clear_to_send_n <= chg_a.lvl[0];
      ct0_clock <= chg_a.lvl[2];
      transmit_clock_in <= chg_a.lvl[3];
      receive_clock_in <= chg_a.lvl[4];
      baud_generator_clock0 <= chg_a.lvl[4];
      baud_generator_clock1 <= chg_a.lvl[6];
      ct1_clock <= chg_a.lvl[7];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      set_ready_n <= 1'b0;
      ring_indicator_n <= 1'b0;
      carrier_detect_n <= 1'b0;
    end else begin
      set_ready_n <= chg_b.lvl[2];
      ring_indicator_n <= chg_b.lvl[6];
      carrier_detect_n <= chg_b.lvl[4];
    end
  end

  // ---- change reporting: hidden while disabled or driving
  assign rep_a = chg_a.flag & en_a_r & in_mode_a;
  assign rep_b = chg_b.flag & en_b_r & in_mode_b & `UIO_PB_PINS;

  // reading a change register clears every flag of its pins, reported or hidden
  always_comb begin
    clr_a = '0;
    clr_b = '0;
    if (bus_rd) begin
      unique case (bus_addr)
        `UIO_RA_CHG_AU: clr_a[7:4] = 4'hf;
        `UIO_RA_CHG_AL: clr_a[3:0] = 4'hf;
        `UIO_RA_CHG_BU: begin
          clr_b[6] = 1'b1;
          clr_b[4] = 1'b1;
        end
        `UIO_RA_CHG_BL: begin
          clr_b[3] = 1'b1;
          clr_b[2] = 1'b1;
          clr_b[0] = 1'b1;
        end
        default: begin
          clr_a = '0;
        end
      endcase
    end
  end

  assign chg_a.clr = clr_a;
  assign chg_b.clr = clr_b;

  // ---- read mux
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (bus_addr)
      `UIO_RA_CHG_AU: rdata_nxt = {rep_a[7:4], chg_a.lvl[7:4]};
      `UIO_RA_CHG_AL: rdata_nxt = {rep_a[3:0], chg_a.lvl[3:0]};
      `UIO_RA_LVL_A: rdata_nxt = chg_a.lvl;
      `UIO_RA_CHG_BU: begin
        rdata_nxt = {1'b0, rep_b[6], 1'b0, rep_b[4],
                     1'b0, chg_b.lvl[6], 1'b0, chg_b.lvl[4]};
      end
      `UIO_RA_CHG_BL: begin
        rdata_nxt = {rep_b[3], rep_b[2], 1'b0, rep_b[0],
                     chg_b.lvl[3], chg_b.lvl[2], 1'b0, chg_b.lvl[0]};
      end
      `UIO_RA_LVL_B: rdata_nxt = chg_b.lvl & `UIO_PB_PINS;
      `UIO_A_ENA: rdata_nxt = en_a_r;
      `UIO_A_ENB: rdata_nxt = en_b_r;
      `UIO_RA_CFG0: rdata_nxt = pin_config_0_r;
      `UIO_RA_CFG1: rdata_nxt = pin_config_1_r;
      `UIO_RA_CFG2: rdata_nxt = pin_config_2_r;
      `UIO_RA_CFG3: rdata_nxt = pin_config_3_r;
      `UIO_RA_CFG3B: rdata_nxt = pin_config_3_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/uio_port_props.sv ====
// assertions on the channel i/o port block top
// assumes the top's register map and pin ports
`default_nettype none
module uio_port_props #(
  parameter int NPIN = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [6:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [NPIN-1:0] pa_in,
  input wire logic [NPIN-1:0] pa_out,
  input wire logic [NPIN-1:0] pa_oe,
  input wire logic [NPIN-1:0] pb_oe,
  input wire logic [NPIN-1:0] output_latch_a,
  input wire logic clear_to_send_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // cycles since reset, saturating; masks synchroniser fill
  logic [2:0] age_r;
  always_ff @(posedge ref_clk) begin
    if (rst) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  sequence s_rd_at(a);
    bus_rd && bus_addr == a;
  endsequence
  sequence s_cfg0(c);
    bus_wr && bus_addr == 7'h13 && bus_wdata[1:0] == c
      ##1 !(bus_wr && bus_addr == 7'h13);
  endsequence
  AST_UNMAPPED: assert property (bus_rd && !(bus_addr inside {7'h13,
    7'h14, 7'h15, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h32, 7'h3a, [7'h40:7'h43]})
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  AST_CFG3_RSVD: assert property (s_rd_at(7'h1c) |=>
    (bus_rdata & 8'hcc) == 8'h00) else $error("cfg3 reserved bits set");
  AST_LVLB_RSVD: assert property (s_rd_at(7'h1d) |=>
    (bus_rdata & 8'ha2) == 8'h00) else $error("port b absent pin set");
  AST_BU_RSVD: assert property (s_rd_at(7'h1b) |=>
    (bus_rdata & 8'haa) == 8'h00) else $error("b upper reserved set");
  AST_LVLA: assert property (age_r == 3'h7 ##0 $stable(pa_in)[*3]
    ##0 s_rd_at(7'h15) |=> bus_rdata == $past(pa_in))
    else $error("port a levels wrong");
  AST_RDATA_HOLD: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  AST_RESET_IN: assert property ($fell(rst) |->
    pa_oe == '0 && pb_oe == '0) else $error("driver on after reset");
  AST_LATCH: assert property (s_cfg0(2'h1) ##1
    $stable(output_latch_a[0]) |-> pa_oe[0] &&
    pa_out[0] == !output_latch_a[0]) else $error("latch drive wrong");
  AST_IN_OFF: assert property (s_cfg0(2'h0) |=> !pa_oe[0])
    else $error("input code drives pin");
  AST_CTS: assert property (age_r == 3'h7 ##0
    $stable(pa_in[0])[*4] |-> clear_to_send_n == pa_in[0])
    else $error("clear to send not following pin");
endmodule
bind uio_port_top uio_port_props #(.NPIN(NPIN)) u_props (
  .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
  .pb_oe(pb_oe), .output_latch_a(output_latch_a),
  .clear_to_send_n(clear_to_send_n));
`default_nettype wire

// ==== testbench/uio_pin_model.sv ====
// far side of the pins: modem, clock and interrupt lines
// assumes out/oe pairs per pin; far side follows ext when released
`default_nettype none
module uio_pin_model (
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  output logic [7:0] pa_in,
  output logic [7:0] pb_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // block drive wins; open-drain pins fall back to ext (pull-up)
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
endmodule
`default_nettype wire

// ==== testbench/uio_port_config_bench.sv ====
// self-checking bench of the channel i/o port block
// assumes the pin model as far side and a 100 MHz clock
`default_nettype none
module uart_io_port_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, bus_wr, bus_rd, rts_en, eot_en, rts_n, eot_n;
  logic [6:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, pa_in, pa_out, pa_oe, pb_in, pb_out;
  logic [7:0] pb_oe, lat_a, lat_b, ext_a, ext_b, d;
  logic [6:0] src;
  logic [1:0] int_n;
  wire [9:0] alt;
  int n_errors, total_checks;
  logic [6:0] ra [7] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h1c, 7'h32, 7'h3a};
  uio_port_top u_dut (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .output_latch_a(lat_a),
    .output_latch_b(lat_b), .rts_mode_en(rts_en), .eot_mode_en(eot_en),
    .request_to_send_n(rts_n), .end_of_tx_n(eot_n),
    .transmit_clock_16x(src[0]), .transmit_clock_1x(src[1]),
    .chb_transmit_clock_1x(src[2]), .receive_clock_16x(src[3]),
    .receive_clock_1x(src[4]), .ct0_out(src[5]), .ct1_out(src[6]),
    .transmit_interrupt_out_n(int_n[0]),
    .receive_interrupt_out_n(int_n[1]), .clear_to_send_n(alt[0]),
    .ct0_clock(alt[1]), .transmit_clock_in(alt[2]),
    .receive_clock_in(alt[3]), .baud_generator_clock0(alt[4]),
    .baud_generator_clock1(alt[5]), .ct1_clock(alt[6]),
    .set_ready_n(alt[7]), .carrier_detect_n(alt[8]),
    .ring_indicator_n(alt[9]));
  uio_pin_model u_pins (.ext_a(ext_a), .ext_b(ext_b), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .pa_in(pa_in),
    .pb_in(pb_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    cyc(1);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    cyc(1);
    bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    cyc(1);
    bus_addr = a;
    bus_rd = 1'b1;
    cyc(1);
    bus_rd = 1'b0;
    v = bus_rdata;
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic t_reset();
    foreach (ra[i]) rc(ra[i], 8'h00);
    chk(pa_oe | pb_oe, 8'h00);
    rc(7'h7f, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_porta();
    lat_a = 8'h5a;
    wr(7'h13, 8'h55);
    wr(7'h14, 8'h55);
    cyc(2);
    chk(pa_oe, 8'hff);
    chk(pa_out, ~lat_a);
    src[3:0] = 4'b1101;
    // pin 1 and 6 reserved codes, pin 0 input, others alternate or latch
    wr(7'h13, 8'hac);
    wr(7'h14, 8'hb6);
    cyc(2);
    chk(pa_oe, 8'hbc);
    chk(pa_out & 8'hbc, 8'hb8);
    rc(7'h40, 8'hac);
    rc(7'h41, 8'hb6);
    wr(7'h13, 8'h00);
    wr(7'h14, 8'h00);
    $display("port a test done");
  endtask
  task automatic t_portb();
    wr(7'h1b, 8'hff);
    rc(7'h42, 8'hf3);
    wr(7'h1c, 8'hff);
    rc(7'h1c, 8'h33);
    lat_b = 8'h01;
    src[6:5] = 2'b10;
    int_n = 2'b10;
    wr(7'h1b, 8'hf1);
    wr(7'h1c, 8'h22);
    cyc(2);
    chk(pb_oe & 8'h5d, 8'h49);
    chk(pb_out & 8'h49, 8'h00);
    // both modes on, end-of-tx line low: request-to-send must win
    rts_en = 1'b1;
    rts_n = 1'b1;
    eot_en = 1'b1;
    cyc(2);
    chk({7'h0, pb_out[0]}, 8'h01);
    rts_en = 1'b0;
    eot_n = 1'b1;
    cyc(2);
    chk({7'h0, pb_out[0]}, 8'h01);
    eot_en = 1'b0;
    cyc(2);
    chk({7'h0, pb_out[0]}, 8'h00);
    wr(7'h1b, 8'h00);
    wr(7'h1c, 8'h00);
    $display("port b test done");
  endtask
  task automatic t_levels();
    ext_a = 8'h3c;
    ext_b = 8'hff;
    cyc(4);
    rc(7'h15, 8'h3c);
    rc(7'h1d, 8'h5d);
    chk(alt[7:0], 8'h9e);
    chk({6'h0, alt[9:8]}, 8'h03);
    $display("level test done");
  endtask
  task automatic t_change();
    wr(7'h32, 8'h0f);
    wr(7'h3a, 8'hff);
    rc(7'h3a, 8'h5d);
    rd(7'h14, d);
    rd(7'h13, d);
    rd(7'h1b, d);
    ext_a = 8'h1d;
    cyc(5);
    rc(7'h14, 8'h1d);
    rc(7'h13, 8'h01);
    rc(7'h14, 8'h0d);
    // pin 0 as output, toggled by the latch, far side kept equal
    wr(7'h13, 8'h01);
    cyc(2);
    lat_a[0] = 1'b1;
    cyc(5);
    rd(7'h14, d);
    chk(d & 8'h10, 8'h00);
    lat_a[0] = 1'b0;
    cyc(5);
    wr(7'h13, 8'h00);
    cyc(4);
    rd(7'h14, d);
    chk(d & 8'h10, 8'h10);
    ext_b = 8'hb7;
    cyc(5);
    rc(7'h1b, 8'h41);
    rc(7'h1a, 8'h85);
    $display("change test done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end
  initial begin
    {bus_wr, bus_rd, rts_en, eot_en, rts_n, eot_n} = 6'h00;
    bus_addr = 7'h00;
    bus_wdata = 8'h00;
    {lat_a, lat_b, ext_a} = 24'h000000;
    ext_b = 8'hff;
    src = 7'h00;
    int_n = 2'h3;
    n_errors = 0;
    total_checks = 0;
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    t_reset();
    t_porta();
    t_portb();
    t_levels();
    t_change();
    close_out();
  end
endmodule
`default_nettype wire
